// ### sim/cip_checker_assertions.sv
// port assertions for the component input block
`timescale 1ns/1ps
`default_nettype none
`include "comp_input_consts.vh"
module cip_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic converter_port_oe,
  input wire logic converter_clock_source_select,
  input wire logic clamp_mode_bit,
  input wire logic reference_mode_active,
  input wire logic clamp_enable,
  input wire logic source_switch_indicator_in,
  input wire logic gain_loop_reset,
  input wire logic [8:0] gain_three_code,
  input wire logic [8:0] gain_four_code,
  input wire logic static_mode_group_high
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rst_en_q;
  wire w23 = reg_write && reg_addr == `CIP_ADDR_ANALOG_CTRL;
  wire w24 = reg_write && reg_addr == `CIP_ADDR_GAIN_THREE;
  wire w25 = reg_write && reg_addr == `CIP_ADDR_GAIN_FOUR;
  wire w29 = reg_write && reg_addr == `CIP_ADDR_DELAY_SWITCH;
  // shadow of the indicator enable bit
  always @(posedge clk or negedge resetn) begin
    if (!resetn) rst_en_q <= 1'b0;
    else if (w23) rst_en_q <= reg_wdata[2];
  end
  property p_port_drive;
    w23 |=> converter_port_oe == $past(reg_wdata[6]);
  endproperty
  a_port_drive: assert property (p_port_drive) else $error("port drive wrong");
  property p_clk_src;
    w23 |=> converter_clock_source_select == $past(reg_wdata[5]);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source wrong");
  property p_ref_mode;
    w23 |=> reference_mode_active == $past(reg_wdata[4]);
  endproperty
  a_ref_mode: assert property (p_ref_mode) else $error("reference mode wrong");
  property p_clamp;
    clamp_enable == (!reference_mode_active && clamp_mode_bit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp enable wrong");
  property p_loop_reset;
    rst_en_q && $changed(source_switch_indicator_in) |-> ##[0:2] gain_loop_reset;
  endproperty
  a_loop_reset: assert property (p_loop_reset) else $error("gain reset missing");
  property p_gain3_low;
    w24 |=> gain_three_code[7:0] == $past(reg_wdata);
  endproperty
  a_gain3_low: assert property (p_gain3_low) else $error("gain three low wrong");
  property p_gain4_low;
    w25 |=> gain_four_code[7:0] == $past(reg_wdata);
  endproperty
  a_gain4_low: assert property (p_gain4_low) else $error("gain four low wrong");
  property p_gain_top;
    w23 |=> {gain_four_code[8], gain_three_code[8]} == $past(reg_wdata[1:0]);
  endproperty
  a_gain_top: assert property (p_gain_top) else $error("gain top bits wrong");
  property p_static;
    w29 |=> static_mode_group_high == (!$past(reg_wdata[7]) && $past(reg_wdata[6]));
  endproperty
  a_static: assert property (p_static) else $error("static group wrong");
endmodule
bind component_input_processing cip_checker i_cip_checker (.clk(clk), .resetn(resetn),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .converter_port_oe(converter_port_oe),
  .converter_clock_source_select(converter_clock_source_select),
  .clamp_mode_bit(clamp_mode_bit), .reference_mode_active(reference_mode_active),
  .clamp_enable(clamp_enable), .source_switch_indicator_in(source_switch_indicator_in),
  .gain_loop_reset(gain_loop_reset), .gain_three_code(gain_three_code),
  .gain_four_code(gain_four_code), .static_mode_group_high(static_mode_group_high));
`default_nettype wire

// ### sim/pixel_partner.sv
// video source and output sink at the block's pixel side
`timescale 1ns/1ps
`default_nettype none
module pixel_partner (
  input wire logic clk,
  input wire logic sink_hold,
  input wire logic pix_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_y,
  input wire logic [7:0] out_c,
  input wire logic out_is_component,
  output logic pix_valid,
  output logic out_ready,
  output logic [7:0] cvbs_y,
  output logic [7:0] cvbs_c,
  output logic [7:0] comp_y,
  output logic [7:0] comp_c,
  output logic pixel_switch_input
);
  integer seed = 32'h0c90ce07;
  integer got = 0;
  logic [7:0] last_y, last_c;
  logic last_comp, acc;
  initial begin
    pix_valid = 1'b0;
    out_ready = 1'b0;
    {cvbs_y, cvbs_c, comp_y, comp_c} = 32'h0;
    pixel_switch_input = 1'b0;
  end
  // sink stalls at random
  always @(negedge clk) out_ready <= !sink_hold && ($random(seed) % 4 != 0);
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      last_y <= out_y;
      last_c <= out_c;
      last_comp <= out_is_component;
      got <= got + 1;
    end
  end
  // synchronous sources: composite and component carry fixed levels per run
  task automatic send(input int n, input logic [31:0] v, input logic sw);
    int k;
    k = 0;
    acc = 1'b0;
    @(negedge clk);
    {cvbs_y, cvbs_c, comp_y, comp_c} = v;
    pixel_switch_input = sw;
    while (k < n) begin
      if (acc || !pix_valid) pix_valid = $random(seed) % 3 != 0;
      acc = pix_valid && pix_ready;
      @(posedge clk);
      if (acc) k++;
      @(negedge clk);
    end
    pix_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the component input block
`timescale 1ns/1ps
`default_nettype none
`include "comp_input_consts.vh"
module testbench;
  logic clk, resetn, reg_write, clamp_mode_bit, ind, sink_hold, oe, clk_sel, ref_act, aosh;
  logic clamp_en, glr, static_hi, pix_valid, pix_ready, sw, out_valid, out_ready, out_comp;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, adc, port_out, out_y, out_c, d;
  logic [7:0] cvbs_y, cvbs_c, comp_y, comp_c, r29, con, sat, bri, ey, ec;
  logic [8:0] g3, g4, gv;
  logic [31:0] v, w;
  logic sel;
  integer seed = 32'h0c90ce07;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i, k, n, e, s, dl, yc, yo;
  logic [7:0] ra [8] = '{8'h23, 8'h24, 8'h25, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30};
  logic [7:0] re [8] = '{8'h00, 8'h90, 8'h90, 8'h00, 8'h80, 8'h40, 8'h40, 8'h00};
  logic [7:0] ctab [5] = '{8'h40, 8'h7f, 8'h00, 8'hc0, 8'h80};
  component_input_processing i_component_input_processing (.clk(clk), .resetn(resetn),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_sample_in(adc), .converter_port_out(port_out), .converter_port_oe(oe),
    .converter_clock_source_select(clk_sel), .analog_output_select_high(aosh),
    .clamp_mode_bit(clamp_mode_bit), .reference_mode_active(ref_act),
    .clamp_enable(clamp_en), .source_switch_indicator_in(ind), .gain_loop_reset(glr),
    .gain_three_code(g3), .gain_four_code(g4), .static_mode_group_high(static_hi),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .cvbs_y(cvbs_y), .cvbs_c(cvbs_c),
    .comp_y(comp_y), .comp_c(comp_c), .pixel_switch_input(sw), .out_valid(out_valid),
    .out_ready(out_ready), .out_y(out_y), .out_c(out_c), .out_is_component(out_comp));
  pixel_partner i_pixel_partner (.clk(clk), .sink_hold(sink_hold), .pix_ready(pix_ready),
    .out_valid(out_valid), .out_y(out_y), .out_c(out_c), .out_is_component(out_comp),
    .pix_valid(pix_valid), .out_ready(out_ready), .cvbs_y(cvbs_y), .cvbs_c(cvbs_c),
    .comp_y(comp_y), .comp_c(comp_c), .pixel_switch_input(sw));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = x;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] x);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    x = reg_rdata;
  endtask
  task drain;
    k = 0;
    while (out_valid !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("drained", 16'h0, 16'(out_valid));
  endtask
  function automatic logic [7:0] clip(input int x);
    if (x < 0) return 8'h00;
    if (x > 255) return 8'hff;
    return x[7:0];
  endfunction
  initial begin
    {resetn, reg_write, reg_addr, reg_wdata, adc, clamp_mode_bit, ind, sink_hold} = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk("reset read", 16'(re[i]), 16'(d));
    end
    chk("reset gain", 16'h090, 16'(g3));
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      d = i < 2 ? {8{i[0]}} : 8'($random(seed));
      clamp_mode_bit = $random(seed);
      adc = $random(seed);
      wr(`CIP_ADDR_ANALOG_CTRL, d);
      chk("port oe", 16'(d[6]), 16'(oe));
      chk("port data", 16'(adc), 16'(port_out));
      chk("clock src", 16'(d[5]), 16'(clk_sel));
      chk("clamp", 16'(!d[4] && clamp_mode_bit), 16'(clamp_en));
      chk("ref", 16'(d[4]), 16'(ref_act));
      chk("gain3 top", 16'(d[0]), 16'(g3[8]));
      chk("gain4 top", 16'(d[1]), 16'(g4[8]));
      chk("out sel high", 16'(d[7]), 16'(aosh));
      rd(`CIP_ADDR_ANALOG_CTRL, ey);
      chk("ctrl read", 16'(d & `CIP_ANALOG_CTRL_MASK), 16'(ey));
    end
    wr(8'h30, 8'hff);
    rd(8'h30, d);
    chk("unmapped", 16'h0, 16'(d));
    for (i = 0; i < 4; i++) begin
      gv = i == 0 ? 9'd0 : i == 1 ? 9'd144 : i == 2 ? 9'd511 : 9'($random(seed));
      wr(`CIP_ADDR_ANALOG_CTRL, {6'h0, gv[8], gv[8]});
      wr(`CIP_ADDR_GAIN_THREE, gv[7:0]);
      wr(`CIP_ADDR_GAIN_FOUR, ~gv[7:0]);
      chk("gain3", 16'(gv), 16'(g3));
      chk("gain4", 16'({gv[8], ~gv[7:0]}), 16'(g4));
    end
    $display("test registers done");
    for (i = 0; i < 2; i++) begin
      wr(`CIP_ADDR_ANALOG_CTRL, {5'h0, i[0], 2'h0});
      n = 0;
      repeat (2) begin
        @(negedge clk);
        ind = ~ind;
        repeat (4) begin
          @(posedge clk);
          #1 n += glr;
        end
      end
      chk("gain loop resets", 16'(i * 2), 16'(n));
    end
    $display("test source switch done");
    for (i = 0; i < 16; i++) begin
      con = i < 5 ? ctab[i] : 8'($random(seed));
      sat = i < 5 ? ctab[4 - i] : 8'($random(seed));
      bri = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
      r29 = i < 4 ? {i[1:0], 6'h0} : 8'($random(seed));
      v = $random(seed);
      sel = $random(seed);
      wr(`CIP_ADDR_CONTRAST, con);
      wr(`CIP_ADDR_SATURATION, sat);
      wr(`CIP_ADDR_BRIGHTNESS, bri);
      wr(`CIP_ADDR_DELAY_SWITCH, r29);
      chk("static group", 16'(!r29[7] && r29[6]), 16'(static_hi));
      i_pixel_partner.send(48, v, sel);
      drain;
      sel = r29[7] ? sel ^ r29[6] : r29[6];
      ey = sel ? clip(((int'(v[15:8]) * int'($signed(con))) >>> 6) + int'(bri) - 128) : v[31:24];
      ec = sel ? clip((((int'(v[7:0]) - 128) * int'($signed(sat))) >>> 6) + 128) : v[23:16];
      chk("out select", 16'(sel), 16'(i_pixel_partner.last_comp));
      chk("out luma", 16'(ey), 16'(i_pixel_partner.last_y));
      chk("out chroma", 16'(ec), 16'(i_pixel_partner.last_c));
    end
    $display("test pixel path done");
    wr(`CIP_ADDR_CONTRAST, 8'h40);
    wr(`CIP_ADDR_SATURATION, 8'h40);
    wr(`CIP_ADDR_BRIGHTNESS, 8'h80);
    // step from v to w; last word's centre sits just before or on the step
    for (i = 0; i < 32; i++) begin
      r29 = 8'($random(seed));
      r29 = i < 16 ? {2'b01, r29[5:3], i[3:1]} : r29;
      e = i % 2;
      s = $signed(r29[2:0]);
      dl = $signed(r29[5:4]);
      v = $random(seed);
      w = $random(seed);
      wr(`CIP_ADDR_DELAY_SWITCH, r29);
      i_pixel_partner.send(48, v, 1'b0);
      drain;
      i_pixel_partner.send(21 + 4 * s + e, w, 1'b1);
      drain;
      sel = r29[7] ? (e > dl) ^ r29[6] : r29[6];
      yc = e ? w[15:8] : v[15:8];
      yo = e ? v[15:8] : w[15:8];
      ey = r29[3] ? clip(yc + ((yc - yo) >>> 3)) : 8'(yc);
      ec = e ? w[7:0] : v[7:0];
      if (!sel) ey = 4 * s + e > 0 ? w[31:24] : v[31:24];
      if (!sel) ec = 4 * s + e > 0 ? w[23:16] : v[23:16];
      chk("delay select", 16'(sel), 16'(i_pixel_partner.last_comp));
      chk("delay luma", 16'(ey), 16'(i_pixel_partner.last_y));
      chk("delay chroma", 16'(ec), 16'(i_pixel_partner.last_c));
    end
    $display("test delay done");
    sink_hold = 1'b1;
    n = i_pixel_partner.got;
    i_pixel_partner.send(8, 32'h0, 1'b0);
    @(negedge clk);
    chk("fifo full ready", 16'h0, 16'(pix_ready));
    chk("fifo full valid", 16'h1, 16'(out_valid));
    sink_hold = 1'b0;
    drain;
    chk("fifo words", 16'h8, 16'(i_pixel_partner.got - n));
    $display("test buffer done");
    close_out;
  end
endmodule
`default_nettype wire

// ### verilog/comp_input_consts.vh
// register map, field positions, reset values and delay figures of the component input block
`ifndef COMP_INPUT_CONSTS_VH
`define COMP_INPUT_CONSTS_VH

`define CIP_ADDR_ANALOG_CTRL 8'h23
`define CIP_ADDR_GAIN_THREE 8'h24
`define CIP_ADDR_GAIN_FOUR 8'h25
`define CIP_ADDR_DELAY_SWITCH 8'h29
`define CIP_ADDR_BRIGHTNESS 8'h2a
`define CIP_ADDR_CONTRAST 8'h2b
`define CIP_ADDR_SATURATION 8'h2c

`define CIP_BIT_OUT_SEL_HIGH 7
`define CIP_BIT_PORT_DRIVE 6
`define CIP_BIT_CLK_SOURCE 5
`define CIP_BIT_REF_CLAMP 4
`define CIP_BIT_SRC_RESET_EN 2
`define CIP_BIT_GAIN_FOUR_TOP 1
`define CIP_BIT_GAIN_THREE_TOP 0
`define CIP_ANALOG_CTRL_MASK 8'hf7

`define CIP_BIT_SWITCH_EN 7
`define CIP_BIT_SWITCH_POL 6
`define CIP_SWITCH_DELAY_HI 5
`define CIP_SWITCH_DELAY_LO 4
`define CIP_BIT_PEAKING 3
`define CIP_PATH_DELAY_HI 2
`define CIP_PATH_DELAY_LO 0

`define CIP_RST_ANALOG_CTRL 8'h00
`define CIP_RST_GAIN_LOW 8'h90
`define CIP_RST_DELAY_SWITCH 8'h00
`define CIP_RST_BRIGHTNESS 8'h80
`define CIP_RST_CONTRAST 8'h40
`define CIP_RST_SATURATION 8'h40

`define CIP_DELAY_BASE 6'd18
`define CIP_GAIN_SHIFT 6
`define CIP_PEAK_SHIFT 3
`define CIP_CHROMA_ZERO 10'sd128
`define CIP_BRIGHT_ZERO 18'sd128

`endif

// ### verilog/component_input_processing.v
// component input control registers and component/composite pixel datapath
// Function
// - port drive bit 0 tri-states converter output port, 1 drives it
// - clock select bit picks line-locked clock (0) or external clock (1)
// - reference bit 0 clamps per clamp-mode bit; 1 pulls signal into range
// - with reset enable set, any edge on indicator resets gain loop
// - channel three gain is 9 bits: top bit in 23h, low byte in 24h
// - channel four gain is 9 bits: top bit in 23h, low byte in 25h
// - switch enable chooses composite or component pixel by pixel
// - polarity 0: low input picks composite; polarity 1 inverts it
// - switching off: polarity bit statically selects mode group
// - switch delay field shifts switch signal by 0, +1, -2, -1 pixels
// - peaking bit adds up to about +3.5 dB high-frequency luma boost to component path
// - path delay field shifts component by 0..+12 or -16..-4 pixels
// - brightness is unsigned offset, 128 nominal
// - contrast is signed gain in 1/64 steps, 64 is unity
// - saturation uses contrast coding on chrominance
`timescale 1ns/1ps
`default_nettype none
`include "comp_input_consts.vh"
module component_input_processing #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter DELAY_DEPTH = 32
) (
  input wire clk,
  input wire resetn,
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] adc_sample_in,
  output reg [7:0] converter_port_out,
  output wire converter_port_oe,
  output wire converter_clock_source_select,
  output wire analog_output_select_high,
  input wire clamp_mode_bit,
  output wire reference_mode_active,
  output wire clamp_enable,
  input wire source_switch_indicator_in,
  output reg gain_loop_reset,
  output wire [8:0] gain_three_code,
  output wire [8:0] gain_four_code,
  output wire static_mode_group_high,
  input wire pix_valid,
  output wire pix_ready,
  input wire [7:0] cvbs_y,
  input wire [7:0] cvbs_c,
  input wire [7:0] comp_y,
  input wire [7:0] comp_c,
  input wire pixel_switch_input,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_y,
  output wire [7:0] out_c,
  output wire out_is_component
);
  reg [7:0] analog_control_five_q;
  reg [7:0] gain_three_low_q;
  reg [7:0] gain_four_low_q;
  reg [7:0] delay_switch_q;
  reg [7:0] component_brightness_code_q;
  reg [7:0] component_contrast_code_q;
  reg [7:0] component_saturation_code_q;
  reg [7:0] rdata_d;

  // multiply by signed 1/64 gain code
  function signed [17:0] scale_gain;
    input signed [9:0] value;
    input signed [7:0] gain;
    reg signed [17:0] prod;
    begin
      prod = value * gain;
      scale_gain = prod >>> `CIP_GAIN_SHIFT;
    end
  endfunction

  // saturate to 0..255
  function [7:0] clip8;
    input signed [17:0] x;
    begin
      if (x < 18'sd0) begin
        clip8 = 8'h00;
      end else if (x > 18'sd255) begin
        clip8 = 8'hff;
      end else begin
        clip8 = x[7:0];
      end
    end
  endfunction

  // register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_control_five_q <= `CIP_RST_ANALOG_CTRL;
      gain_three_low_q <= `CIP_RST_GAIN_LOW;
      gain_four_low_q <= `CIP_RST_GAIN_LOW;
      delay_switch_q <= `CIP_RST_DELAY_SWITCH;
      component_brightness_code_q <= `CIP_RST_BRIGHTNESS;
      component_contrast_code_q <= `CIP_RST_CONTRAST;
      component_saturation_code_q <= `CIP_RST_SATURATION;
    end else if (reg_write) begin
      case (reg_addr)
        `CIP_ADDR_ANALOG_CTRL: begin
          analog_control_five_q <= reg_wdata & `CIP_ANALOG_CTRL_MASK;
        end
        `CIP_ADDR_GAIN_THREE: begin
          gain_three_low_q <= reg_wdata;
        end
        `CIP_ADDR_GAIN_FOUR: begin
          gain_four_low_q <= reg_wdata;
        end
        `CIP_ADDR_DELAY_SWITCH: begin
          delay_switch_q <= reg_wdata;
        end
        `CIP_ADDR_BRIGHTNESS: begin
          component_brightness_code_q <= reg_wdata;
        end
        `CIP_ADDR_CONTRAST: begin
          component_contrast_code_q <= reg_wdata;
        end
        `CIP_ADDR_SATURATION: begin
          component_saturation_code_q <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the address
  always @* begin
    case (reg_addr)
      `CIP_ADDR_ANALOG_CTRL: rdata_d = analog_control_five_q;
      `CIP_ADDR_GAIN_THREE: rdata_d = gain_three_low_q;
      `CIP_ADDR_GAIN_FOUR: rdata_d = gain_four_low_q;
      `CIP_ADDR_DELAY_SWITCH: rdata_d = delay_switch_q;
      `CIP_ADDR_BRIGHTNESS: rdata_d = component_brightness_code_q;
      `CIP_ADDR_CONTRAST: rdata_d = component_contrast_code_q;
      `CIP_ADDR_SATURATION: rdata_d = component_saturation_code_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // analog side controls
  assign converter_port_oe = analog_control_five_q[`CIP_BIT_PORT_DRIVE];
  assign converter_clock_source_select = analog_control_five_q[`CIP_BIT_CLK_SOURCE];
  assign analog_output_select_high = analog_control_five_q[`CIP_BIT_OUT_SEL_HIGH];
  assign reference_mode_active = analog_control_five_q[`CIP_BIT_REF_CLAMP];
  assign clamp_enable = ~analog_control_five_q[`CIP_BIT_REF_CLAMP] & clamp_mode_bit;
  assign gain_three_code = {analog_control_five_q[`CIP_BIT_GAIN_THREE_TOP], gain_three_low_q};
  assign gain_four_code = {analog_control_five_q[`CIP_BIT_GAIN_FOUR_TOP], gain_four_low_q};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converter_port_out <= 8'h00;
    end else begin
      converter_port_out <= adc_sample_in;
    end
  end

  // source switch indicator edge detect
  reg indicator_prev_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      indicator_prev_q <= 1'b0;
      gain_loop_reset <= 1'b0;
    end else begin
      indicator_prev_q <= source_switch_indicator_in;
      gain_loop_reset <= analog_control_five_q[`CIP_BIT_SRC_RESET_EN] &
                         (source_switch_indicator_in ^ indicator_prev_q);
    end
  end

  // pixel path control fields
  wire switch_en;
  wire switch_pol;
  wire peaking_en;
  wire [1:0] pixel_switch_delay;
  wire [2:0] component_path_delay;
  wire [5:0] comp_tap_wide;
  wire [5:0] switch_tap_wide;
  wire fifo_in_ready;
  wire advance;

  assign switch_en = delay_switch_q[`CIP_BIT_SWITCH_EN];
  assign switch_pol = delay_switch_q[`CIP_BIT_SWITCH_POL];
  assign peaking_en = delay_switch_q[`CIP_BIT_PEAKING];
  assign pixel_switch_delay = delay_switch_q[`CIP_SWITCH_DELAY_HI:`CIP_SWITCH_DELAY_LO];
  assign component_path_delay = delay_switch_q[`CIP_PATH_DELAY_HI:`CIP_PATH_DELAY_LO];
  assign static_mode_group_high = ~switch_en & switch_pol;

  // path delay code is signed steps of four pixels
  assign comp_tap_wide = `CIP_DELAY_BASE +
    {component_path_delay[2], component_path_delay, 2'b00};
  // switch delay code is signed pixels relative to component
  assign switch_tap_wide = comp_tap_wide +
    {{4{pixel_switch_delay[1]}}, pixel_switch_delay};

  assign pix_ready = fifo_in_ready;
  assign advance = pix_valid & fifo_in_ready;

  wire [15:0] cvbs_tap;
  wire [15:0] comp_tap;
  wire [0:0] switch_tap;
  // composite path sits at the fixed base tap 18, the zero of the path delay range
  wire [5:0] cvbs_tap_wide;
  assign cvbs_tap_wide = `CIP_DELAY_BASE;

  pixel_delay_line #(.WIDTH(16), .DEPTH(DELAY_DEPTH), .TAP_W(5)) u_cvbs_delay (
    .clk(clk),
    .resetn(resetn),
    .advance(advance),
    .din({cvbs_y, cvbs_c}),
    .tap(cvbs_tap_wide[4:0]),
    .dout(cvbs_tap)
  );

  pixel_delay_line #(.WIDTH(16), .DEPTH(DELAY_DEPTH), .TAP_W(5)) u_comp_delay (
    .clk(clk),
    .resetn(resetn),
    .advance(advance),
    .din({comp_y, comp_c}),
    .tap(comp_tap_wide[4:0]),
    .dout(comp_tap)
  );

  pixel_delay_line #(.WIDTH(1), .DEPTH(DELAY_DEPTH), .TAP_W(5)) u_switch_delay (
    .clk(clk),
    .resetn(resetn),
    .advance(advance),
    .din(pixel_switch_input),
    .tap(switch_tap_wide[4:0]),
    .dout(switch_tap)
  );

  // stage one: luma history for peaking, other paths aligned to centre
  reg [7:0] luma_h1_q;
  reg [7:0] luma_h2_q;
  reg [7:0] comp_c_q;
  reg [15:0] cvbs_q;
  reg switch_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      luma_h1_q <= 8'h00;
      luma_h2_q <= 8'h00;
      comp_c_q <= 8'h00;
      cvbs_q <= 16'h0000;
      switch_q <= 1'b0;
    end else if (advance) begin
      luma_h1_q <= comp_tap[15:8];
      luma_h2_q <= luma_h1_q;
      comp_c_q <= comp_tap[7:0];
      cvbs_q <= cvbs_tap;
      switch_q <= switch_tap[0];
    end
  end

  // stage two arithmetic
  wire signed [17:0] high_pass;
  wire signed [17:0] peaked;
  wire [7:0] luma_src;
  wire signed [17:0] luma_scaled;
  wire [7:0] luma_out;
  wire signed [17:0] chroma_scaled;
  wire [7:0] chroma_out;
  wire select_component;

  // 2*centre minus both neighbours, eighth of it added back
  assign high_pass = $signed({9'd0, luma_h1_q, 1'b0}) - $signed({10'd0, comp_tap[15:8]}) -
                     $signed({10'd0, luma_h2_q});
  assign peaked = $signed({10'd0, luma_h1_q}) + (high_pass >>> `CIP_PEAK_SHIFT);
  assign luma_src = peaking_en ? clip8(peaked) : luma_h1_q;

  assign luma_scaled = scale_gain($signed({2'b00, luma_src}),
                                  $signed(component_contrast_code_q)) +
                       $signed({10'd0, component_brightness_code_q}) -
                       `CIP_BRIGHT_ZERO;
  assign luma_out = clip8(luma_scaled);

  assign chroma_scaled = scale_gain($signed({2'b00, comp_c_q}) - `CIP_CHROMA_ZERO,
                                    $signed(component_saturation_code_q)) +
                         `CIP_BRIGHT_ZERO;
  assign chroma_out = clip8(chroma_scaled);

  // per-pixel choice or static choice
  assign select_component = switch_en ? (switch_q ^ switch_pol) : switch_pol;

  reg [7:0] mix_y_q;
  reg [7:0] mix_c_q;
  reg mix_comp_q;
  reg [1:0] fill_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mix_y_q <= 8'h00;
      mix_c_q <= 8'h00;
      mix_comp_q <= 1'b0;
      fill_q <= 2'd0;
    end else if (advance) begin
      mix_y_q <= select_component ? luma_out : cvbs_q[15:8];
      mix_c_q <= select_component ? chroma_out : cvbs_q[7:0];
      mix_comp_q <= select_component;
      if (fill_q != 2'd2) begin
        fill_q <= fill_q + 2'd1;
      end
    end
  end

  wire [16:0] fifo_out;
  // first two accepted pixels only fill the pipeline
  wire fifo_push;
  assign fifo_push = advance & (fill_q == 2'd2);

  pixel_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_out_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({mix_comp_q, mix_y_q, mix_c_q}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  assign out_is_component = fifo_out[16];
  assign out_y = fifo_out[15:8];
  assign out_c = fifo_out[7:0];
endmodule
`default_nettype wire

// ### verilog/pixel_delay_line.v
// tapped delay line for pixel samples, advancing on each accepted pixel
`timescale 1ns/1ps
`default_nettype none
module pixel_delay_line #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter TAP_W = 5
) (
  input wire clk,
  input wire resetn,
  input wire advance,
  input wire [WIDTH-1:0] din,
  input wire [TAP_W-1:0] tap,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] line_q [0:DEPTH-1];
  integer i;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        line_q[i] <= {WIDTH{1'b0}};
      end
    end else if (advance) begin
      line_q[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1) begin
        line_q[i] <= line_q[i-1];
      end
    end
  end

  // tap 0 is the newest stored sample
  assign dout = line_q[tap];
endmodule
`default_nettype wire

// ### verilog/pixel_fifo.v
// synchronous output fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_q];

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire
